//--- rtl/hrp_top.sv
`timescale 1ns/1ps
module hrp_top (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       srst,
  // Power-up mode strap
  input  wire logic [2:0] mode_strap,
  // Chip select, driven by device in memory mode
  input  wire logic       cs_n_in,
  output logic            cs_n_out,
  output logic            cs_n_oe,
  // Host strobes
  input  wire logic       ale,
  input  wire logic       rd_n,
  input  wire logic       wr_n,
  // Address bus, driven by device in memory mode
  input  wire logic [6:0] addr_in,
  output logic [6:0]      addr_out,
  output logic            addr_oe,
  // Shared address/data bus
  input  wire logic [7:0] ad_in,
  output logic [7:0]      ad_out,
  output logic            ad_oe,
  // Ready handshake
  output logic            rdy_out,
  output logic            rdy_oe,
  // Serial port
  input  wire logic       sclk,
  input  wire logic       serial_in,
  input  wire logic       serial_edge_select,
  output logic            serial_out,
  output logic            serial_out_oe,
  // Current mode
  output logic [hrp_pkg::MODE_FIELD_W-1:0] host_port_mode_field
);
  import hrp_pkg::*;

  // ----------------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------------
  hrp_pins_if pins ();

  // Collect raw pads
  always_comb begin
    pins.raw.cs_n               = cs_n_in;
    pins.raw.ale                = ale;
    pins.raw.rd_n               = rd_n;
    pins.raw.wr_n               = wr_n;
    pins.raw.ad                 = ad_in;
    pins.raw.addr               = addr_in;
    pins.raw.sclk               = sclk;
    pins.raw.serial_in          = serial_in;
    pins.raw.serial_edge_select = serial_edge_select;
    pins.raw.mode_strap         = mode_strap;
  end

  hrp_sync u_sync (
    .ref_clk (ref_clk),
    .pins    (pins.sync_side)
  );

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    hrp_state_e            st;        // Access state
    logic [6:0]            addr;      // Latched register address
    logic [3:0]            cnt;       // Ready low counter
    logic [7:0]            dout;      // Read data to bus
    logic                  ad_oe;     // Bus drive enable
    logic                  rdy;       // Ready level
    logic                  ale_d;     // Delayed synced strobes
    logic                  rd_d;
    logic                  wr_d;
    logic                  sclk_d;
    logic [6:0]            boot_idx;  // Boot load address
    logic [4:0]            boot_cnt;  // Boot access wait
    logic                  eprom_cs;  // Device drives chip select
    logic [4:0]            sbit;      // Serial bit index
    logic [7:0]            sin;       // Serial shift in
    logic [7:0]            sout;      // Serial shift out
    logic                  srd;       // Serial frame is a read
    logic [6:0]            saddr;     // Serial address
    logic [REG_COUNT-1:0][7:0] regs;  // Register file
  } hrp_core_s;

  hrp_core_s  r;          // Registered state
  hrp_core_s  next_r;     // Next state
  hrp_pins_s  q;          // Synced pins
  logic [2:0] mode;       // Mode field
  logic       cs_act;     // Host selects device
  logic       ale_fall;   // Address strobe fell
  logic       rd_fall;    // Read strobe fell
  logic       rd_rise;    // Read strobe rose
  logic       wr_fall;    // Write strobe fell
  logic       wr_rise;    // Write strobe rose
  logic       bus_mode;   // A strobed parallel mode
  logic       ser_edge;   // Selected serial clock edge
  logic [6:0] acc_addr;   // Address of a strobed access

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  assign q        = pins.sync;
  assign mode     = r.regs[MODE_SELECT_OFF][MODE_FIELD_LSB +: MODE_FIELD_W];
  assign cs_act   = ~q.cs_n;
  assign ale_fall = r.ale_d & ~q.ale;
  assign rd_fall  = r.rd_d & ~q.rd_n;
  assign rd_rise  = ~r.rd_d & q.rd_n;
  assign wr_fall  = r.wr_d & ~q.wr_n;
  assign wr_rise  = ~r.wr_d & q.wr_n;
  assign bus_mode = (mode == MODE_MUXED) || (mode == MODE_SEPBUS) || (mode == MODE_SINGLE);
  // Edge select high samples on rising, low on falling
  assign ser_edge = q.serial_edge_select ? (~r.sclk_d & q.sclk) : (r.sclk_d & ~q.sclk);
  // Muxed uses latched address, other modes the address pins
  assign acc_addr = (mode == MODE_MUXED) ? r.addr : q.addr;

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    next_r        = r;
    next_r.ale_d  = q.ale;
    next_r.rd_d   = q.rd_n;
    next_r.wr_d   = q.wr_n;
    next_r.sclk_d = q.sclk;

    unique case (r.st)
      // Catch the strap once it is through the synchroniser
      ST_START: begin
        next_r.regs[MODE_SELECT_OFF] = {5'h00, q.mode_strap};
        if (q.mode_strap == MODE_EPROM) begin
          next_r.st       = ST_BOOT;
          next_r.eprom_cs = 1'b1;
          next_r.boot_idx = 7'h00;
          next_r.boot_cnt = 5'(EPROM_WAIT_CYC);
        end else begin
          next_r.st = ST_IDLE;
        end
      end
      // Walk the memory, one register per access time
      ST_BOOT: begin
        if (r.boot_cnt != 5'h00) begin
          next_r.boot_cnt = r.boot_cnt - 5'h01;
        end else begin
          next_r.regs[r.boot_idx] = q.ad;
          if (r.boot_idx == BOOT_LAST_OFF) begin
            next_r.st       = ST_IDLE;
            next_r.eprom_cs = 1'b0;
          end else begin
            next_r.boot_idx = r.boot_idx + 7'h01;
            next_r.boot_cnt = 5'(EPROM_WAIT_CYC);
          end
        end
      end
      // Wait for a strobe while selected
      ST_IDLE: begin
        if (cs_act && bus_mode) begin
          if (ale_fall && mode == MODE_MUXED) begin
            next_r.addr = q.ad[6:0];
          end
          if (rd_fall) begin
            next_r.st    = ST_READ;
            next_r.dout  = r.regs[acc_addr];
            next_r.ad_oe = 1'b1;
            next_r.rdy   = 1'b0;
            next_r.cnt   = 4'(READ_RDY_CYC - 1);
          end else if (wr_fall) begin
            next_r.st   = ST_WRITE;
            next_r.addr = acc_addr;
            next_r.rdy  = 1'b0;
            next_r.cnt  = 4'(WRITE_RDY_CYC - 1);
          end
        end
      end
      // Ready low for the least time, then high until strobe ends
      ST_READ: begin
        if (r.cnt != 4'h0) begin
          next_r.cnt = r.cnt - 4'h1;
        end else begin
          next_r.rdy = 1'b1;
        end
        if (rd_rise) begin
          next_r.st    = ST_END;
          next_r.ad_oe = 1'b0;
          next_r.rdy   = 1'b0;
        end
      end
      // Write count from WRITE_RDY_CYC - 1; data taken at strobe rise
      ST_WRITE: begin
        if (r.cnt != 4'h0) begin
          next_r.cnt = r.cnt - 4'h1;
        end else begin
          next_r.rdy = 1'b1;
        end
        if (wr_rise) begin
          next_r.regs[r.addr] = q.ad;
          next_r.st           = ST_END;
          next_r.rdy          = 1'b0;
        end
      end
      // Ready held low until deselect
      ST_END: begin
        next_r.rdy = 1'b0;
        if (!cs_act) begin
          next_r.st = ST_IDLE;
        end
      end
    endcase

    // Deselect aborts any host access
    if (!cs_act && r.st != ST_BOOT && r.st != ST_START) begin
      next_r.st    = ST_IDLE;
      next_r.ad_oe = 1'b0;
      next_r.rdy   = 1'b0;
    end

    // Serial frame: r/w bit, 7 address bits, 8 data bits, msb first
    if (!(cs_act && mode == MODE_SERIAL)) begin
      next_r.sbit = 5'h00;
    end else if (ser_edge) begin
      next_r.sin  = {r.sin[6:0], q.serial_in};
      next_r.sbit = r.sbit + 5'h01;
      if (r.sbit == 5'h00) begin
        next_r.srd = q.serial_in;
      end
      if (r.sbit == SER_ADDR_LAST) begin
        next_r.saddr = {r.sin[5:0], q.serial_in};
        next_r.sout  = r.regs[{r.sin[5:0], q.serial_in}];
      end else if (r.sbit > SER_ADDR_LAST) begin
        next_r.sout = {r.sout[6:0], 1'b0};
      end
      if (r.sbit == SER_DATA_LAST && !r.srd) begin
        next_r.regs[r.saddr] = {r.sin[6:0], q.serial_in};
      end
    end

    // Synchronous reset
    if (srst) begin
      next_r    = '0;
      next_r.st = ST_START;
      // Strobes idle high, so no false edge after release
      next_r.rd_d = 1'b1;
      next_r.wr_d = 1'b1;
      for (int i = 0; i < REG_COUNT; i++) begin
        next_r.regs[i] = REG_RESET;
      end
    end
  end

  // Register the copy
  always_ff @(posedge ref_clk) begin
    r <= next_r;
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign cs_n_out             = 1'b0;
  assign cs_n_oe              = r.eprom_cs;
  assign addr_out             = r.boot_idx;
  assign addr_oe              = r.eprom_cs;
  assign ad_out               = r.dout;
  assign ad_oe                = r.ad_oe;
  assign rdy_out              = r.rdy;
  assign rdy_oe               = cs_act && bus_mode && r.st != ST_START;
  assign serial_out           = r.sout[7];
  assign serial_out_oe        = cs_act && mode == MODE_SERIAL && r.srd
                                && r.sbit > SER_ADDR_LAST;
  assign host_port_mode_field = mode;

endmodule

//--- rtl/hrp_pkg.sv
package hrp_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam int unsigned REG_COUNT        = 128;          // 7-bit register space
  localparam logic [6:0]  MODE_SELECT_OFF  = 7'h7F;        // host_port_mode_select
  localparam int unsigned MODE_FIELD_LSB   = 0;            // host_port_mode_field lsb
  localparam int unsigned MODE_FIELD_W     = 3;            // host_port_mode_field width
  localparam logic [7:0]  REG_RESET        = 8'h00;        // Plain registers after reset
  localparam logic [6:0]  BOOT_LAST_OFF    = 7'h7E;        // Last register loaded at boot

  // ----------------------------------------------------------------------
  // Interface mode codes
  // ----------------------------------------------------------------------
  localparam logic [2:0] MODE_EPROM   = 3'h1;              // Self boot from memory
  localparam logic [2:0] MODE_MUXED   = 3'h2;              // Shared address/data bus
  localparam logic [2:0] MODE_SEPBUS  = 3'h3;              // Separate bus, two strobes
  localparam logic [2:0] MODE_SINGLE  = 3'h4;              // Single strobe variant
  localparam logic [2:0] MODE_SERIAL  = 3'h5;              // Serial port

  // ----------------------------------------------------------------------
  // Timing, times in picoseconds, counts in stages or ref_clk cycles
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_PS          = 50000;         // ref_clk period
  localparam int unsigned MASTER_T_PS     = 12860;         // Master clock period T
  localparam int unsigned PAD_MARGIN_PS   = 10000;         // The +10 ns term
  localparam int unsigned EPROM_ACC_PS    = 920000;        // Memory access time
  localparam int unsigned SYNC_STAGES     = 2;             // Pin synchroniser depth

  // Longest time to read data: 3.5T + 10 ns, rounded down
  localparam int unsigned READ_DATA_PS    = (7 * MASTER_T_PS) / 2 + PAD_MARGIN_PS;
  localparam int unsigned READ_DATA_CYC   =
    (READ_DATA_PS / CLK_PS < 1) ? 1 : READ_DATA_PS / CLK_PS;
  // Least ready low on read: 4.5T + 10 ns, rounded up
  localparam int unsigned READ_RDY_PS     = (9 * MASTER_T_PS) / 2 + PAD_MARGIN_PS;
  localparam int unsigned READ_RDY_CYC    = (READ_RDY_PS + CLK_PS - 1) / CLK_PS;
  // Least ready low on write: 1.5T + 10 ns, rounded up
  localparam int unsigned WRITE_RDY_PS    = (3 * MASTER_T_PS) / 2 + PAD_MARGIN_PS;
  localparam int unsigned WRITE_RDY_CYC   = (WRITE_RDY_PS + CLK_PS - 1) / CLK_PS;
  // Device waits at least the access time, plus synchroniser lag
  localparam int unsigned EPROM_ACC_CYC   = (EPROM_ACC_PS + CLK_PS - 1) / CLK_PS;
  localparam int unsigned EPROM_WAIT_CYC  = EPROM_ACC_CYC + SYNC_STAGES;

  // ----------------------------------------------------------------------
  // Serial frame layout
  // ----------------------------------------------------------------------
  localparam logic [4:0] SER_ADDR_LAST = 5'h07;            // Bit index of last addr bit
  localparam logic [4:0] SER_DATA_LAST = 5'h0F;            // Bit index of last data bit

  // ----------------------------------------------------------------------
  // Pin bundle
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic       cs_n;       // Chip select, active low
    logic       ale;        // Address latch strobe
    logic       rd_n;       // Read strobe
    logic       wr_n;       // Write strobe
    logic [7:0] ad;         // Shared address/data bus
    logic [6:0] addr;       // Separate address bus
    logic       sclk;       // Serial clock
    logic       serial_in;  // Serial data in
    logic       serial_edge_select; // Serial sampling edge
    logic [2:0] mode_strap; // Mode at power-up
  } hrp_pins_s;

  // Host port states
  typedef enum logic [2:0] {
    ST_START,
    ST_BOOT,
    ST_IDLE,
    ST_READ,
    ST_WRITE,
    ST_END
  } hrp_state_e;

endpackage

//--- rtl/hrp_pins_if.sv
`timescale 1ns/1ps
interface hrp_pins_if;
  import hrp_pkg::*;

  hrp_pins_s raw;   // Straight from the pads
  hrp_pins_s sync;  // After the synchroniser

  // Synchroniser side
  modport sync_side (
    input  raw,
    output sync
  );

  // Core logic side
  modport core_side (
    output raw,
    input  sync
  );
endinterface

//--- rtl/hrp_sync.sv
`timescale 1ns/1ps
module hrp_sync (
  // Clock
  input  wire logic ref_clk,
  // Pins in, synced out
  hrp_pins_if.sync_side pins
);
  import hrp_pkg::*;

  // ----------------------------------------------------------------------
  // Two flop stages
  // ----------------------------------------------------------------------
  typedef struct packed {
    hrp_pins_s meta;  // First stage, read only by second
    hrp_pins_s sync;  // Second stage, safe to use
  } hrp_sync_s;

  hrp_sync_s r;       // Registered state
  hrp_sync_s next_r;  // Next state

  // Data pipe only, so no reset keeps the strap visible at release
  always_comb begin
    next_r      = r;
    next_r.meta = pins.raw;
    next_r.sync = r.meta;
  end

  // Register the copy
  always_ff @(posedge ref_clk) begin
    r <= next_r;
  end

  assign pins.sync = r.sync;

endmodule

//--- bench/hrp_top_chk.sv
`timescale 1ns/1ps
// ------------------------------------------
// Host port checker
// ------------------------------------------
module hrp_top_chk (
  // Clock and reset
  input wire logic       ref_clk,
  input wire logic       srst,
  // Host pins
  input wire logic       cs_n_in,
  input wire logic       rd_n,
  input wire logic       wr_n,
  // Device outputs
  input wire logic       cs_n_oe,
  input wire logic [6:0] addr_out,
  input wire logic       addr_oe,
  input wire logic       ad_oe,
  input wire logic       rdy_out,
  input wire logic       rdy_oe,
  input wire logic [hrp_pkg::MODE_FIELD_W-1:0] host_port_mode_field
);
  import hrp_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  logic bus_mode;  // Modes with a ready handshake
  assign bus_mode = host_port_mode_field inside {MODE_MUXED, MODE_SEPBUS, MODE_SINGLE};
  // Ready only driven in bus modes
  property p_mode_gate; !bus_mode |-> !rdy_oe; endproperty
  a_mode_gate: assert property (p_mode_gate)
    else $error("ready driven outside a bus mode");
  // Read data driven soon after the read strobe
  property p_read_data; $fell(rd_n) && !cs_n_in && bus_mode |-> ##[1:5] ad_oe; endproperty
  a_read_data: assert property (p_read_data)
    else $error("read data late");
  // Ready low two cycles on a read, then high
  property p_read_rdy; $rose(ad_oe) |-> !rdy_out [*2] ##1 rdy_out; endproperty
  a_read_rdy: assert property (p_read_rdy)
    else $error("read ready width wrong");
  // Ready low on a write, then high
  property p_write_rdy;
    $fell(wr_n) && !cs_n_in && bus_mode && !rdy_out |-> !rdy_out [*3] ##[1:4] rdy_out;
  endproperty
  a_write_rdy: assert property (p_write_rdy)
    else $error("write ready width wrong");
  // Bus released after the read strobe rises
  property p_bus_release; $rose(rd_n) && ad_oe |-> ##[1:4] !ad_oe; endproperty
  a_bus_release: assert property (p_bus_release)
    else $error("bus not released");
  // Ready drops after a strobe ends
  property p_rdy_drop; ($rose(rd_n) || $rose(wr_n)) && rdy_out |-> ##[1:4] !rdy_out; endproperty
  a_rdy_drop: assert property (p_rdy_drop)
    else $error("ready not dropped");
  // Ready released after deselect
  property p_rdy_release; $rose(cs_n_in) |-> ##[1:3] !rdy_oe; endproperty
  a_rdy_release: assert property (p_rdy_release)
    else $error("ready not released");
  // Quiet while not selected
  property p_idle_quiet; cs_n_in [*4] |-> !rdy_oe && !ad_oe; endproperty
  a_idle_quiet: assert property (p_idle_quiet)
    else $error("drive while deselected");
  // Boot address held at least eight cycles after each change
  property p_boot_hold; addr_oe && $changed(addr_out) |=> $stable(addr_out) [*8]; endproperty
  a_boot_hold: assert property (p_boot_hold)
    else $error("boot address too short");
  // Boot drives its own chip select
  property p_boot_cs;
    host_port_mode_field == MODE_EPROM && addr_oe |-> cs_n_oe && !ad_oe;
  endproperty
  a_boot_cs: assert property (p_boot_cs)
    else $error("boot without chip select");
endmodule

bind hrp_top hrp_top_chk u_chk (
  .ref_clk(ref_clk), .srst(srst), .cs_n_in(cs_n_in), .rd_n(rd_n), .wr_n(wr_n),
  .cs_n_oe(cs_n_oe), .addr_out(addr_out), .addr_oe(addr_oe), .ad_oe(ad_oe),
  .rdy_out(rdy_out), .rdy_oe(rdy_oe), .host_port_mode_field(host_port_mode_field)
);

//--- bench/hrp_eprom_model.sv
`timescale 1ns/1ps
// ------------------------------------------
// Boot memory model
// ------------------------------------------
module hrp_eprom_model #(
  parameter int ACC_CYC = 17  // Access time, small is prompt
) (
  // Clock
  input  wire logic       ref_clk,
  // Device side
  input  wire logic       cs_n,
  input  wire logic [6:0] addr,
  // Data toward the bus
  output logic      [7:0] data
);
  logic [6:0] last_addr;  // Address one cycle ago
  int         age = 0;    // Cycles since select or address change
  initial data = 8'h55;
  // Access timer restarts on any change
  always @(posedge ref_clk) begin
    last_addr <= addr;
    if (cs_n || addr != last_addr) begin
      age <= 0;
    end else if (age < ACC_CYC) begin
      age <= age + 1;
    end
  end
  // Image once the access time is over, a moving pattern before
  always @(posedge ref_clk) begin
    if (!cs_n && addr == last_addr && age >= ACC_CYC - 1) begin
      data <= {1'b1, addr} ^ 8'h3C;
    end else begin
      data <= ~data;
    end
  end
endmodule

//--- bench/hrp_top_bench.sv
`timescale 1ns/1ps
// ------------------------------------------
// Host port bench
// ------------------------------------------
module hrp_top_bench;
  import hrp_pkg::*;
  logic                    ref_clk = 1'b0;   // 20 MHz
  logic                    srst = 1'b1;      // Sync reset
  logic [2:0]              mode_strap = 3'h2;
  logic                    host_cs_n = 1'b1; // Host side pins
  logic                    ale = 1'b0;
  logic                    rd_n = 1'b1;
  logic                    wr_n = 1'b1;
  logic [6:0]              host_addr = 7'h00;
  logic [7:0]              host_ad = 8'h00;
  logic                    host_oe = 1'b0;
  logic                    sclk = 1'b0;      // Serial pins
  logic                    ser_in = 1'b0;
  logic                    ser_edge_sel = 1'b1;
  logic                    ser_out, ser_oe;
  logic                    cs_n_out, cs_n_oe, addr_oe, ad_oe, rdy_out, rdy_oe;
  logic [6:0]              addr_out;
  logic [7:0]              ad_out, rom_ad;
  logic [MODE_FIELD_W-1:0] mode_field;
  logic                    cs_wire;          // Resolved wires
  logic [6:0]              addr_wire;
  logic [7:0]              ad_wire;
  int                      failures = 0;
  int                      compares = 0;
  logic [7:0]              q;
  int                      i;
  int                      n;
  // Clock
  always #25 ref_clk = ~ref_clk;
  // Pin resolution
  assign cs_wire   = cs_n_oe ? cs_n_out : host_cs_n;
  assign addr_wire = addr_oe ? addr_out : host_addr;
  assign ad_wire   = ad_oe ? ad_out : (host_oe ? host_ad : rom_ad);
  hrp_top u_dut (
    .ref_clk(ref_clk), .srst(srst), .mode_strap(mode_strap), .cs_n_in(cs_wire),
    .cs_n_out(cs_n_out), .cs_n_oe(cs_n_oe), .ale(ale), .rd_n(rd_n), .wr_n(wr_n),
    .addr_in(addr_wire), .addr_out(addr_out), .addr_oe(addr_oe), .ad_in(ad_wire),
    .ad_out(ad_out), .ad_oe(ad_oe), .rdy_out(rdy_out), .rdy_oe(rdy_oe), .sclk(sclk),
    .serial_in(ser_in), .serial_edge_select(ser_edge_sel), .serial_out(ser_out),
    .serial_out_oe(ser_oe),
    .host_port_mode_field(mode_field)
  );
  hrp_eprom_model #(.ACC_CYC(17)) u_rom (
    .ref_clk(ref_clk), .cs_n(cs_wire), .addr(addr_wire), .data(rom_ad)
  );
  // ------------------------------------------
  // Shared tasks
  // ------------------------------------------
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("Comparisons %0d mismatches %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic do_reset(input logic [2:0] strap);
    @(posedge ref_clk);
    srst       <= 1'b1;
    mode_strap <= strap;
    repeat (8) @(posedge ref_clk);
    srst <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask
  // One host access, mux selects the shared bus address phase
  task automatic access(input logic mux, input logic wr, input logic [6:0] a,
                        input logic [7:0] d, input logic exp_rdy, output logic [7:0] rq);
    int k;
    @(posedge ref_clk);
    host_cs_n <= 1'b0;
    host_addr <= a;
    host_ad   <= {1'b0, a};
    host_oe   <= mux;
    ale       <= mux;
    repeat (2) @(posedge ref_clk);
    ale <= 1'b0;
    repeat (2) @(posedge ref_clk);
    host_ad <= d;
    host_oe <= wr;
    if (wr) begin
      wr_n <= 1'b0;
    end else begin
      rd_n <= 1'b0;
    end
    for (k = 0; k < 20; k++) begin
      @(posedge ref_clk);
      if (rdy_oe === 1'b1 && rdy_out === 1'b1) break;
    end
    rq = ad_wire;
    check("ready", {7'h00, k < 20}, {7'h00, exp_rdy});
    rd_n <= 1'b1;
    wr_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    host_cs_n <= 1'b1;
    host_oe   <= 1'b0;
    repeat (6) @(posedge ref_clk);
  endtask
  // One serial frame, 16 bits msb first; out bits taken before each active edge
  task automatic ser_frame(input logic [15:0] f, output logic [7:0] rq);
    int b;
    rq = 8'h00;
    @(posedge ref_clk);
    host_cs_n <= 1'b0;
    for (b = 15; b >= 0; b--) begin
      ser_in <= f[b];
      repeat (4) @(posedge ref_clk);
      if (b < 8) rq = {rq[6:0], ser_out};
      if (b == 0) check("ser_oe", {7'h00, ser_oe}, {7'h00, f[15]});
      sclk <= 1'b1;
      repeat (4) @(posedge ref_clk);
      sclk <= 1'b0;
      repeat (4) @(posedge ref_clk);
    end
    host_cs_n <= 1'b1;
    repeat (6) @(posedge ref_clk);
  endtask
  // ------------------------------------------
  // Scenarios
  // ------------------------------------------
  task automatic t_mux_regs();
    do_reset(MODE_MUXED);
    check("mode", {5'h00, mode_field}, {5'h00, MODE_MUXED});
    access(1'b1, 1'b1, 7'h05, 8'hA5, 1'b1, q);
    access(1'b1, 1'b1, 7'h7E, 8'h3C, 1'b1, q);
    access(1'b1, 1'b0, 7'h05, 8'h00, 1'b1, q);
    check("rd05", q, 8'hA5);
    access(1'b1, 1'b0, 7'h7E, 8'h00, 1'b1, q);
    check("rd7e", q, 8'h3C);
    access(1'b1, 1'b0, 7'h10, 8'h00, 1'b1, q);
    check("rd10", q, REG_RESET);
    access(1'b1, 1'b0, MODE_SELECT_OFF, 8'h00, 1'b1, q);
    check("rd7f", q, {5'h00, MODE_MUXED});
  endtask
  task automatic t_refuse();
    @(posedge ref_clk);
    rd_n <= 1'b0;
    for (n = 0; n < 6; n++) begin
      @(posedge ref_clk);
      check("deselect", {6'h00, ad_oe, rdy_oe}, 8'h00);
    end
    rd_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
  endtask
  task automatic t_modes();
    access(1'b1, 1'b1, MODE_SELECT_OFF, {5'h00, MODE_SEPBUS}, 1'b1, q);
    check("mode", {5'h00, mode_field}, {5'h00, MODE_SEPBUS});
    access(1'b0, 1'b0, 7'h05, 8'h00, 1'b1, q);
    check("sep05", q, 8'hA5);
    access(1'b0, 1'b1, 7'h06, 8'h5A, 1'b1, q);
    access(1'b0, 1'b1, MODE_SELECT_OFF, {5'h00, MODE_SINGLE}, 1'b1, q);
    check("mode", {5'h00, mode_field}, {5'h00, MODE_SINGLE});
    access(1'b0, 1'b0, 7'h06, 8'h00, 1'b1, q);
    check("sgl06", q, 8'h5A);
    access(1'b0, 1'b1, MODE_SELECT_OFF, {5'h00, MODE_SERIAL}, 1'b1, q);
    check("mode", {5'h00, mode_field}, {5'h00, MODE_SERIAL});
    access(1'b0, 1'b0, 7'h05, 8'h00, 1'b0, q);
  endtask
  // Serial write on rising edges, reads back on falling edges
  task automatic t_serial();
    ser_edge_sel <= 1'b1;
    ser_frame({1'b0, 7'h20, 8'hC3}, q);
    ser_edge_sel <= 1'b0;
    ser_frame({1'b1, 7'h20, 8'h00}, q);
    check("ser20", q, 8'hC3);
    ser_frame({1'b1, 7'h06, 8'h00}, q);
    check("ser06", q, 8'h5A);
  endtask
  task automatic t_boot();
    do_reset(MODE_EPROM);
    check("mode", {5'h00, mode_field}, {5'h00, MODE_EPROM});
    for (i = 0; i <= BOOT_LAST_OFF; i++) begin
      for (n = 0; n < 40 && !(addr_oe === 1'b1 && addr_out === i[6:0]); n++) begin
        @(posedge ref_clk);
      end
      check("boot_addr", {1'b0, addr_out}, i[7:0]);
      check("boot_cs", {7'h00, cs_n_oe}, 8'h01);
    end
    for (n = 0; n < 40 && addr_oe !== 1'b0; n++) begin
      @(posedge ref_clk);
    end
    check("boot_end", {7'h00, addr_oe}, 8'h00);
    // Every loaded register holds the memory image
    for (i = 0; i <= BOOT_LAST_OFF; i++) begin
      check("boot_data", u_dut.r.regs[i], {1'b1, i[6:0]} ^ 8'h3C);
    end
  endtask
  // Main sequence
  initial begin
    t_mux_regs();
    t_refuse();
    t_modes();
    t_serial();
    t_boot();
    wrap_up();
  end
  // Watchdog
  initial begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    wrap_up();
  end
endmodule
